// ---- core/motor_cmd_defines.svh ----
// Command codes, frame layout figures and timing counts for the motor command link
`ifndef MOTOR_CMD_DEFINES_SVH
`define MOTOR_CMD_DEFINES_SVH
// Command codes, seven bits wide
`define POSITION_QUERY_CMD     7'h00
`define FULL_DIAG_QUERY_CMD    7'h01
`define FUSE_READBACK_CMD      7'h02
`define BRIEF_DIAG_QUERY_CMD   7'h03
`define SAFE_PARK_CMD          7'h04
`define IMMEDIATE_HALT_CMD     7'h05
`define ZERO_ORIGIN_CMD        7'h06
`define RAM_RESTORE_CMD        7'h07
`define TWO_LEG_MOVE_CMD       7'h08
`define MOTION_CONFIG_CMD      7'h09
`define FUSE_PROGRAM_CMD       7'h10
`define ABSOLUTE_MOVE_CMD      7'h0b
`define COMPACT_MOVE_1_CMD     7'h0c
`define COMPACT_MOVE_2_CMD     7'h0d
`define COMPACT_MOVE_4_CMD     7'h0e
`define RAMPED_HALT_CMD        7'h0f
// Safe parking target width, reset value and the "skip parking" value
`define SAFE_PARK_WIDTH        11
`define SAFE_PARK_SKIP         11'h400
`define SAFE_PARK_DEFAULT      11'h400
// Type 5 direct identifier: bits 5 and 4 give the four-byte length
`define DIRECT_ID_LEN_BITS     2'b10
// Fixed identifier byte of the indirect read 6 answer
`define INDIRECT_RESP_ID       8'h7d
// Filler byte of unused response bytes
`define FILL_BYTE              8'hff
// Consecutive empty frame slots before the bus counts as lost
`define BUS_LOST_SLOTS         25000
// Frame slot: 1.30 s over 25000 slots is 52 us per slot
`define SLOT_TIME_NS           52000
`define CLK_PERIOD_NS          10
`define SLOT_CYCLES            (`SLOT_TIME_NS / `CLK_PERIOD_NS)
`endif

// ---- core/motor_cmd_pkg.sv ----
// Types shared by both ends of the motor command link
package motor_cmd_pkg;
  // Frame types as numbered on the bus; 0 marks no frame
  typedef enum logic [3:0] {
    FRAME_NONE = 4'h0,
    FRAME_WRITE1 = 4'h1,
    FRAME_WRITE2 = 4'h2,
    FRAME_WRITE3 = 4'h3,
    FRAME_WRITE4 = 4'h4,
    FRAME_READ5 = 4'h5,
    FRAME_READ6 = 4'h6,
    FRAME_PREP7 = 4'h7,
    FRAME_PREP8 = 4'h8,
    FRAME_SLEEP = 4'h9
  } frame_kind_type;
  // Operating states of the node, one-hot
  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'b0001,
    ST_RUN = 4'b0010,
    ST_PARK = 4'b0100,
    ST_SLEEP = 4'b1000
  } node_state_type;
endpackage

// ---- core/motor_cmd_if.sv ----
// Frame-level link between the bus master end and the motor node end
interface motor_cmd_if;
  import motor_cmd_pkg::*;
  logic slot;                   // One-cycle pulse per frame slot
  logic frame_valid;            // Frame present in this slot
  frame_kind_type frame_kind;   // Frame type
  logic [6:0] cmd;              // Command code
  logic broad;                  // Broadcast bit, active at 0
  logic [6:0] addr;             // Node address
  logic [5:0] ident;            // Identifier bits of a direct-ID read
  logic [31:0] data;            // Payload bytes, first byte in [31:24]
  logic resp_valid;             // Node answer pulse
  logic [7:0] resp_ident;       // Identifier byte of the answer
  logic [31:0] resp_data;       // Four answer data bytes, first in [31:24]
  modport master (output slot, frame_valid, frame_kind, cmd, broad, addr, ident, data,
                  input resp_valid, resp_ident, resp_data);
  modport node (input slot, frame_valid, frame_kind, cmd, broad, addr, ident, data,
                output resp_valid, resp_ident, resp_data);
endinterface

// ---- core/motor_node_end.sv ----
// Motor node end: command decoder, position answer and bus-lost handling
`include "motor_cmd_defines.svh"
module motor_node_end #(
  parameter int LOST_SLOTS = `BUS_LOST_SLOTS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  motor_cmd_if.node LINK,
  input wire logic [6:0] NODE_ADDR,
  input wire logic ADDR_PIN_FLOAT,
  input wire logic [15:0] CURRENT_LOCATION,
  input wire logic [7:0] STATUS_FLAGS,
  input wire logic MOTION_SWITCH_STATE,
  input wire logic MOTION_DONE,
  output logic COILS_ENABLE,
  output motor_cmd_pkg::node_state_type NODE_STATE,
  output logic IMMEDIATE_HALT,
  output logic RAMPED_HALT,
  output logic ZERO_ORIGIN,
  output logic RAM_RESTORE,
  output logic MOVE_START,
  output logic [15:0] MOVE_TARGET,
  output logic TWO_LEG_MOVE,
  output logic MOTION_CONFIG,
  output logic FUSE_PROGRAM,
  output logic COMPACT_MOVE,
  output logic [1:0] COMPACT_COUNT,
  output logic [31:0] CMD_DATA,
  output logic [10:0] SAFE_PARK_TARGET,
  output logic BUS_LOST
);
  import motor_cmd_pkg::*;

  // Elaboration check: the slot counter is sixteen bits wide
  if (LOST_SLOTS < 2 || LOST_SLOTS > 65535) begin : gen_bad_lost
    $error("LOST_SLOTS out of range");
  end

  // Address decode: broadcast at 0 or exact address match
  function automatic logic for_me(input logic broad, input logic [6:0] a, input logic [6:0] mine);
    for_me = !broad || (a == mine);
  endfunction

  logic float_meta;              // Synchroniser first stage
  logic float_sync;              // Synchronised floating-address level
  logic [15:0] empty_slots;      // Consecutive slots with no frame
  logic slots_lost;              // Empty-slot limit reached
  logic lost;                    // Combined lost condition
  logic hit;                     // Frame addressed to this node
  logic pending;                 // A prepared read waits for its read 6
  logic [6:0] pending_cmd;       // Code of the prepared read
  logic [7:0] quick_status;      // Brief status byte
  node_state_type state;         // Operating state

  assign hit = LINK.frame_valid && for_me(LINK.broad, LINK.addr, NODE_ADDR);
  assign lost = slots_lost || float_sync;
  // Same byte in the position answer and the brief status answer
  assign quick_status = STATUS_FLAGS;

  // Two-flop synchroniser for the address pin
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      float_meta <= 1'b0;
      float_sync <= 1'b0;
    end else begin
      float_meta <= ADDR_PIN_FLOAT;
      float_sync <= float_meta;
    end
  end

  // Empty-slot counter; any frame restarts it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      empty_slots <= 16'h0000;
      slots_lost <= 1'b0;
    end else if (LINK.slot) begin
      if (LINK.frame_valid) begin
        empty_slots <= 16'h0000;
        slots_lost <= 1'b0;
      end else if (empty_slots == 16'(LOST_SLOTS - 1)) begin
        slots_lost <= 1'b1;
      end else begin
        empty_slots <= empty_slots + 16'h0001;
      end
    end
  end

  // Node state: shutdown until full status; on loss park then sleep, or sleep at once if parking is skipped
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_SHUTDOWN;
    end else begin
      unique case (state)
        ST_SHUTDOWN: begin
          // Only a full status query wakes the node; loss keeps it here
          if (!lost && hit && (LINK.frame_kind == FRAME_PREP7 || LINK.frame_kind == FRAME_PREP8)
              && LINK.cmd == `FULL_DIAG_QUERY_CMD) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (lost) begin
            state <= (SAFE_PARK_TARGET == `SAFE_PARK_SKIP) ? ST_SLEEP : ST_PARK;
          end else if (hit && LINK.frame_kind == FRAME_SLEEP) begin
            state <= ST_SLEEP;
          end
        end
        ST_PARK: begin
          if (MOTION_DONE) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          state <= ST_SLEEP;
        end
        default: begin
          state <= ST_SHUTDOWN;
        end
      endcase
    end
  end

  // Mirrors of state and of the lost condition to the motor side
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NODE_STATE <= ST_SHUTDOWN;
      COILS_ENABLE <= 1'b0;
      BUS_LOST <= 1'b0;
    end else begin
      NODE_STATE <= state;
      COILS_ENABLE <= (state == ST_RUN) || (state == ST_PARK);
      BUS_LOST <= lost;
    end
  end

  // Write command decode into one-cycle strobes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IMMEDIATE_HALT <= 1'b0;
      RAMPED_HALT <= 1'b0;
      ZERO_ORIGIN <= 1'b0;
      RAM_RESTORE <= 1'b0;
      MOVE_START <= 1'b0;
      MOVE_TARGET <= 16'h0000;
      TWO_LEG_MOVE <= 1'b0;
      MOTION_CONFIG <= 1'b0;
      FUSE_PROGRAM <= 1'b0;
      COMPACT_MOVE <= 1'b0;
      COMPACT_COUNT <= 2'h0;
      CMD_DATA <= 32'h0000_0000;
      SAFE_PARK_TARGET <= `SAFE_PARK_DEFAULT;
    end else begin
      IMMEDIATE_HALT <= 1'b0;
      RAMPED_HALT <= 1'b0;
      ZERO_ORIGIN <= 1'b0;
      RAM_RESTORE <= 1'b0;
      MOVE_START <= 1'b0;
      TWO_LEG_MOVE <= 1'b0;
      MOTION_CONFIG <= 1'b0;
      FUSE_PROGRAM <= 1'b0;
      COMPACT_MOVE <= 1'b0;
      if (state == ST_RUN && lost && SAFE_PARK_TARGET != `SAFE_PARK_SKIP) begin
        // Autonomous absolute move to the sign-extended park target
        MOVE_START <= 1'b1;
        MOVE_TARGET <= {{5{SAFE_PARK_TARGET[10]}}, SAFE_PARK_TARGET};
      end else if (state == ST_RUN && hit) begin
        // Frame kind arrives already resolved from its dynamic identifier
        CMD_DATA <= LINK.data;
        unique case (LINK.frame_kind)
          FRAME_WRITE1: begin
            case (LINK.cmd)
              `IMMEDIATE_HALT_CMD: IMMEDIATE_HALT <= 1'b1;
              `RAMPED_HALT_CMD: RAMPED_HALT <= 1'b1;
              `ZERO_ORIGIN_CMD: ZERO_ORIGIN <= 1'b1;
              `RAM_RESTORE_CMD: begin
                RAM_RESTORE <= 1'b1;
                SAFE_PARK_TARGET <= `SAFE_PARK_DEFAULT;
              end
              `SAFE_PARK_CMD: begin
                MOVE_START <= 1'b1;
                MOVE_TARGET <= {{5{SAFE_PARK_TARGET[10]}}, SAFE_PARK_TARGET};
              end
              `ABSOLUTE_MOVE_CMD: begin
                MOVE_START <= 1'b1;
                MOVE_TARGET <= LINK.data[31:16];
              end
              default: ;
            endcase
          end
          FRAME_WRITE2: begin
            // Compact targets, half-step only; motor side applies them
            if (LINK.cmd >= `COMPACT_MOVE_1_CMD && LINK.cmd <= `COMPACT_MOVE_4_CMD) begin
              COMPACT_MOVE <= 1'b1;
              COMPACT_COUNT <= 2'(LINK.cmd - `COMPACT_MOVE_1_CMD);
            end
          end
          FRAME_WRITE3, FRAME_WRITE4: begin
            if (LINK.cmd == `ABSOLUTE_MOVE_CMD) begin
              MOVE_START <= 1'b1;
              MOVE_TARGET <= LINK.data[31:16];
            end else if (LINK.frame_kind == FRAME_WRITE4) begin
              case (LINK.cmd)
                `TWO_LEG_MOVE_CMD: TWO_LEG_MOVE <= 1'b1;
                `MOTION_CONFIG_CMD: begin
                  MOTION_CONFIG <= 1'b1;
                  SAFE_PARK_TARGET <= LINK.data[10:0];
                end
                `FUSE_PROGRAM_CMD: FUSE_PROGRAM <= 1'b1;
                default: ;
              endcase
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Prepared reads: code held until the read 6 that fetches it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pending <= 1'b0;
      pending_cmd <= 7'h00;
    end else if (LINK.frame_valid && (LINK.frame_kind == FRAME_PREP7 || LINK.frame_kind == FRAME_PREP8)) begin
      pending <= hit && LINK.cmd <= `FUSE_READBACK_CMD;
      pending_cmd <= LINK.cmd;
    end else if (LINK.frame_valid && LINK.frame_kind == FRAME_READ6) begin
      pending <= 1'b0;
    end
  end

  // Answers; reading never touches the status flags
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LINK.resp_valid <= 1'b0;
      LINK.resp_ident <= 8'h00;
      LINK.resp_data <= 32'h0000_0000;
    end else begin
      LINK.resp_valid <= 1'b0;
      if (state != ST_SLEEP && LINK.frame_valid && LINK.frame_kind == FRAME_READ5 && LINK.addr == NODE_ADDR
          && (LINK.cmd == `POSITION_QUERY_CMD || LINK.cmd == `BRIEF_DIAG_QUERY_CMD)) begin
        LINK.resp_valid <= 1'b1;
        LINK.resp_ident <= {~^{LINK.ident[3:0]}, ^{LINK.ident[5], LINK.ident[3:0]},
                            `DIRECT_ID_LEN_BITS, LINK.ident[3:0]};
        if (LINK.cmd == `POSITION_QUERY_CMD) begin
          LINK.resp_data <= {MOTION_SWITCH_STATE, NODE_ADDR, CURRENT_LOCATION, quick_status};
        end else begin
          LINK.resp_data <= {MOTION_SWITCH_STATE, NODE_ADDR, quick_status, `FILL_BYTE, `FILL_BYTE};
        end
      end else if (LINK.frame_valid && LINK.frame_kind == FRAME_READ6 && pending) begin
        LINK.resp_valid <= 1'b1;
        LINK.resp_ident <= `INDIRECT_RESP_ID;
        LINK.resp_data <= {MOTION_SWITCH_STATE, NODE_ADDR, CURRENT_LOCATION, quick_status};
      end
    end
  end
endmodule

// ---- core/motor_master_end.sv ----
// Bus master end: paces frame slots and issues one queued frame per slot
`include "motor_cmd_defines.svh"
module motor_master_end #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  motor_cmd_if.master LINK,
  input wire logic REQ_VALID,
  input wire motor_cmd_pkg::frame_kind_type REQ_KIND,
  input wire logic [6:0] REQ_CMD,
  input wire logic REQ_BROAD,
  input wire logic [6:0] REQ_ADDR,
  input wire logic [5:0] REQ_IDENT,
  input wire logic [31:0] REQ_DATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_IDENT,
  output logic [31:0] RSP_DATA
);
  import motor_cmd_pkg::*;

  // Elaboration check: the slot divider is sixteen bits wide
  if (SLOT_CYCLES < 2 || SLOT_CYCLES > 65535) begin : gen_bad_slot
    $error("SLOT_CYCLES out of range");
  end

  logic [15:0] slot_count;  // Divider for the slot pulse
  logic held;               // A request waits for the next slot

  // Slot divider
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      slot_count <= 16'h0000;
      LINK.slot <= 1'b0;
    end else begin
      LINK.slot <= (slot_count == 16'(SLOT_CYCLES - 1));
      slot_count <= (slot_count == 16'(SLOT_CYCLES - 1)) ? 16'h0000 : slot_count + 16'h0001;
    end
  end

  // Request capture and frame launch on the slot after capture
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      held <= 1'b0;
      REQ_READY <= 1'b1;
      LINK.frame_kind <= FRAME_NONE;
      LINK.cmd <= 7'h00;
      LINK.broad <= 1'b1;
      LINK.addr <= 7'h00;
      LINK.ident <= 6'h00;
      LINK.data <= 32'h0000_0000;
      LINK.frame_valid <= 1'b0;
    end else begin
      if (REQ_VALID && REQ_READY) begin
        held <= 1'b1;
        REQ_READY <= 1'b0;
        LINK.frame_kind <= REQ_KIND;
        LINK.cmd <= REQ_CMD;
        LINK.broad <= REQ_BROAD;
        LINK.addr <= REQ_ADDR;
        LINK.ident <= REQ_IDENT;
        LINK.data <= REQ_DATA;
      end
      // Frame is shown for the single cycle of its slot pulse
      if (slot_count == 16'(SLOT_CYCLES - 1) && held) begin
        LINK.frame_valid <= 1'b1;
        held <= 1'b0;
      end else begin
        LINK.frame_valid <= 1'b0;
      end
      if (LINK.frame_valid) begin
        REQ_READY <= 1'b1;
      end
    end
  end

  // Answer capture; low position bits passed as received
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RSP_VALID <= 1'b0;
      RSP_IDENT <= 8'h00;
      RSP_DATA <= 32'h0000_0000;
    end else begin
      RSP_VALID <= LINK.resp_valid;
      if (LINK.resp_valid) begin
        RSP_IDENT <= LINK.resp_ident;
        RSP_DATA <= LINK.resp_data;
      end
    end
  end
endmodule

// ---- tb/motor_cmd_link_sva.sv ----
// Checker of the frame link between the master end and the node end
module motor_cmd_link_sva (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic slot,
  input wire logic frame_valid,
  input wire motor_cmd_pkg::frame_kind_type frame_kind,
  input wire logic [6:0] cmd,
  input wire logic broad,
  input wire logic [6:0] addr,
  input wire logic [5:0] ident,
  input wire logic [31:0] data,
  input wire logic resp_valid,
  input wire logic [7:0] resp_ident,
  input wire logic [31:0] resp_data
);
  import motor_cmd_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // Read frame of one kind and code
  sequence s_read(k, c);
    frame_valid && frame_kind == k && cmd == c;
  endsequence
  // Same read frame followed by the node answer
  sequence s_answered(k, c);
    s_read(k, c) ##1 resp_valid;
  endsequence
  AST_RESP_CAUSE: assert property (resp_valid |-> $past(frame_valid) &&
    $past(frame_kind) inside {FRAME_READ5, FRAME_READ6}) else $error("answer without a read frame");
  AST_RD5_IDENT: assert property (s_answered(FRAME_READ5, 7'h00) |->
    resp_ident[5:4] == 2'b10 && resp_ident[3:0] == ident[3:0]) else $error("bad position identifier");
  AST_RD5_ADDR: assert property (s_answered(FRAME_READ5, 7'h00) |->
    resp_data[30:24] == addr) else $error("bad address byte");
  AST_BRIEF_FILL: assert property (s_answered(FRAME_READ5, 7'h03) |->
    resp_data[15:0] == 16'hffff && resp_ident[5:4] == 2'b10) else $error("bad brief answer");
  AST_RD6_IDENT: assert property (s_answered(FRAME_READ6, 7'h00) |->
    resp_ident == 8'h7d) else $error("bad indirect identifier");
  AST_RD5_REFUSE: assert property (frame_valid && frame_kind == FRAME_READ5 &&
    !(cmd inside {7'h00, 7'h03}) |=> !resp_valid) else $error("answer to a foreign code");
  AST_WRITE_SILENT: assert property (frame_valid && frame_kind inside {FRAME_WRITE1, FRAME_WRITE2,
    FRAME_WRITE3, FRAME_WRITE4, FRAME_SLEEP} |=> !resp_valid) else $error("answer to a write");
  AST_FRAME_IN_SLOT: assert property (frame_valid |-> slot) else $error("frame off slot");
  AST_RESP_SINGLE: assert property (resp_valid |=> !resp_valid) else $error("answer too long");
endmodule

// ---- tb/lin_motor_command_decoder_tb.sv ----
// Bench joining the master end and the node end over the frame link
module lin_motor_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import motor_cmd_pkg::*;
  localparam int SLOTS = 4; // Short slot
  localparam int LOST = 8; // Short lost count
  localparam logic [31:0] WDATA = 32'hfedc0123; // Payload of every write
  typedef struct packed {
    frame_kind_type kind;
    logic [6:0] cmd;
    logic broad;
    logic [6:0] addr;
    logic [8:0] exp;
    logic [1:0] cnt;
  } row_type;
  // Write frames and the strobe each one must give; the last gives none
  row_type rows [15] = '{
    '{FRAME_WRITE1, 7'h05, 1'b1, 7'h15, 9'h100, 2'd0},
    '{FRAME_WRITE1, 7'h0f, 1'b1, 7'h15, 9'h080, 2'd0},
    '{FRAME_WRITE1, 7'h06, 1'b1, 7'h15, 9'h040, 2'd0},
    '{FRAME_WRITE4, 7'h08, 1'b1, 7'h15, 9'h008, 2'd0},
    '{FRAME_WRITE4, 7'h10, 1'b1, 7'h15, 9'h002, 2'd0},
    '{FRAME_WRITE4, 7'h09, 1'b1, 7'h15, 9'h004, 2'd0},
    '{FRAME_WRITE1, 7'h04, 1'b1, 7'h15, 9'h010, 2'd0},
    '{FRAME_WRITE3, 7'h0b, 1'b1, 7'h15, 9'h010, 2'd0},
    '{FRAME_WRITE4, 7'h0b, 1'b1, 7'h15, 9'h010, 2'd0},
    '{FRAME_WRITE1, 7'h0b, 1'b1, 7'h15, 9'h010, 2'd0},
    '{FRAME_WRITE2, 7'h0c, 1'b1, 7'h15, 9'h001, 2'd0},
    '{FRAME_WRITE2, 7'h0d, 1'b1, 7'h15, 9'h001, 2'd1},
    '{FRAME_WRITE2, 7'h0e, 1'b1, 7'h15, 9'h001, 2'd2},
    '{FRAME_WRITE1, 7'h05, 1'b0, 7'h22, 9'h100, 2'd0},
    '{FRAME_WRITE1, 7'h05, 1'b1, 7'h22, 9'h000, 2'd0}
  };
  logic clk = 1'b0; // System clock
  logic reset_n = 1'b0; // Reset, active low
  logic req_valid = 1'b0; // Request strobe
  frame_kind_type req_kind = FRAME_NONE; // Request fields
  logic [6:0] req_cmd = 7'h00;
  logic req_broad = 1'b1;
  logic [6:0] req_addr = 7'h00;
  logic [5:0] req_ident = 6'h00;
  logic [31:0] req_data = 32'h0;
  logic req_ready, rsp_valid; // Master answers
  logic [7:0] rsp_ident;
  logic [31:0] rsp_data;
  logic addr_pin_float = 1'b0; // Node pins
  logic motion_done = 1'b0;
  logic coils_enable, bus_lost;
  node_state_type node_state;
  logic [8:0] stb; // Node strobes, halt first
  logic [15:0] move_target;
  logic [1:0] compact_count;
  logic [10:0] safe_park;
  logic [31:0] cmd_data; // Payload passed to the motor side
  int n_fail = 0; // Mismatches
  int n_checks = 0; // Comparisons
  motor_cmd_if lnk();
  // Clock of 100 MHz
  always #5 clk = ~clk;
  motor_master_end #(.SLOT_CYCLES(SLOTS)) i_motor_master_end (.CLK(clk), .RESET_N(reset_n), .LINK(lnk.master),
    .REQ_VALID(req_valid), .REQ_KIND(req_kind), .REQ_CMD(req_cmd), .REQ_BROAD(req_broad), .REQ_ADDR(req_addr),
    .REQ_IDENT(req_ident), .REQ_DATA(req_data), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_IDENT(rsp_ident), .RSP_DATA(rsp_data));
  motor_node_end #(.LOST_SLOTS(LOST)) i_motor_node_end (.CLK(clk), .RESET_N(reset_n), .LINK(lnk.node),
    .NODE_ADDR(7'h15), .ADDR_PIN_FLOAT(addr_pin_float), .CURRENT_LOCATION(16'h8001), .STATUS_FLAGS(8'ha5),
    .MOTION_SWITCH_STATE(1'b1), .MOTION_DONE(motion_done), .COILS_ENABLE(coils_enable), .NODE_STATE(node_state),
    .IMMEDIATE_HALT(stb[8]), .RAMPED_HALT(stb[7]), .ZERO_ORIGIN(stb[6]), .RAM_RESTORE(stb[5]),
    .MOVE_START(stb[4]), .MOVE_TARGET(move_target), .TWO_LEG_MOVE(stb[3]), .MOTION_CONFIG(stb[2]),
    .FUSE_PROGRAM(stb[1]), .COMPACT_MOVE(stb[0]), .COMPACT_COUNT(compact_count), .CMD_DATA(cmd_data),
    .SAFE_PARK_TARGET(safe_park), .BUS_LOST(bus_lost));
  motor_cmd_link_sva i_motor_cmd_link_sva (.CLK(clk), .RESET_N(reset_n), .slot(lnk.slot),
    .frame_valid(lnk.frame_valid), .frame_kind(lnk.frame_kind), .cmd(lnk.cmd), .broad(lnk.broad),
    .addr(lnk.addr), .ident(lnk.ident), .data(lnk.data), .resp_valid(lnk.resp_valid),
    .resp_ident(lnk.resp_ident), .resp_data(lnk.resp_data));
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A wait that ran out ends the run
  task automatic give_up(input string what);
    n_fail++;
    $display("ERROR %s timed out", what);
    end_sim();
  endtask
  // Reset held for 20 cycles
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    addr_pin_float <= 1'b0;
    motion_done <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  // One frame; returns one cycle after it is on the link
  task automatic send(input frame_kind_type k, input logic [6:0] c, input logic b, input logic [6:0] a);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_cmd <= c;
    req_broad <= b;
    req_addr <= a;
    req_ident <= 6'h2a;
    req_data <= WDATA;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    req_valid <= 1'b0;
    if (i >= 50) give_up("request");
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (lnk.frame_valid !== 1'b1 && i < 50);
    if (i >= 50) give_up("frame");
    @(posedge clk);
    #1;
  endtask
  // Read frame and check whether an answer came
  task automatic rd(input frame_kind_type k, input logic [6:0] c, input logic v);
    send(k, c, 1'b1, 7'h15);
    @(posedge clk);
    #1;
    chk("rsp_valid", rsp_valid, v);
  endtask
  // Bounded wait for a node state
  task automatic wait_st(input node_state_type s);
    int i;
    i = 0;
    while (node_state !== s && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("node_state", node_state, s);
  endtask
  // Main sequence
  initial begin
    do_reset();
    #1;
    chk("park reset", safe_park, 11'h400);
    chk("shutdown", node_state, ST_SHUTDOWN);
    send(FRAME_WRITE1, 7'h05, 1'b1, 7'h15);
    chk("halt refused", stb, 9'h000);
    rd(FRAME_READ5, 7'h03, 1'b1);
    chk("brief", rsp_data, {1'b1, 7'h15, 8'ha5, 16'hffff});
    rd(FRAME_READ5, 7'h01, 1'b0);
    send(FRAME_PREP7, 7'h01, 1'b1, 7'h15);
    wait_st(ST_RUN);
    rd(FRAME_READ5, 7'h00, 1'b1);
    chk("position", rsp_data, {1'b1, 7'h15, 16'h8001, 8'ha5});
    chk("ident", rsp_ident[5:0], 6'h2a);
    send(FRAME_PREP8, 7'h00, 1'b1, 7'h15);
    rd(FRAME_READ6, 7'h00, 1'b1);
    chk("ident6", rsp_ident, 8'h7d);
    chk("read6", rsp_data, {1'b1, 7'h15, 16'h8001, 8'ha5});
    rd(FRAME_READ6, 7'h00, 1'b0);
    send(FRAME_PREP7, 7'h02, 1'b1, 7'h15);
    rd(FRAME_READ6, 7'h02, 1'b1);
    chk("coils on", coils_enable, 1'b1);
    foreach (rows[i]) begin
      send(rows[i].kind, rows[i].cmd, rows[i].broad, rows[i].addr);
      chk("strobes", stb, rows[i].exp);
      if (rows[i].exp[0]) chk("count", compact_count, rows[i].cnt);
    end
    chk("target", move_target, 16'hfedc);
    chk("payload", cmd_data, WDATA);
    chk("park set", safe_park, 11'h123);
    send(FRAME_WRITE1, 7'h07, 1'b1, 7'h15);
    chk("restore", stb, 9'h020);
    chk("park default", safe_park, 11'h400);
    send(FRAME_WRITE4, 7'h09, 1'b1, 7'h15);
    wait_st(ST_PARK);
    chk("lost", bus_lost, 1'b1);
    chk("park move", move_target, 16'h0123);
    @(posedge clk);
    motion_done <= 1'b1;
    wait_st(ST_SLEEP);
    @(posedge clk);
    #1;
    chk("coils off", coils_enable, 1'b0);
    rd(FRAME_READ5, 7'h00, 1'b0);
    do_reset();
    send(FRAME_PREP7, 7'h01, 1'b1, 7'h15);
    wait_st(ST_RUN);
    send(FRAME_SLEEP, 7'h00, 1'b1, 7'h15);
    wait_st(ST_SLEEP);
    do_reset();
    send(FRAME_PREP7, 7'h01, 1'b1, 7'h15);
    wait_st(ST_RUN);
    @(posedge clk);
    addr_pin_float <= 1'b1;
    wait_st(ST_SLEEP);
    chk("float lost", bus_lost, 1'b1);
    do_reset();
    repeat ((LOST + 2) * (SLOTS + 1)) @(posedge clk);
    send(FRAME_PREP7, 7'h01, 1'b1, 7'h15);
    chk("stay shut", node_state, ST_SHUTDOWN);
    chk("coils shut", coils_enable, 1'b0);
    end_sim();
  end
endmodule
